// ### hw/mcs_splitter.sv
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - Split MAC conduit into media, precision-time and management groups
// - No processing besides the register agent; signals pass unchanged
// - Build-time family parameter selects logic and ties off absent interfaces
// - Option 0: no speed register; MAC speed passes straight through
// - Option 1: speed register drives the media-side speed output
// - Speed-register option derived from the family, never set directly
// - Agent port on peripheral clock; native family keeps clock, reset and agent, which refuses every access
// - One-word-per-address agent, separate read and write, 32-bit data
// - 2-bit MAC speed input used only in the native-speed family
// - Transmit data, enable and error forwarded unchanged to media side
// - Receive data, valid, error, collision, carrier returned unchanged
// - Management out and enable forwarded; management in returned
// - Pulse-per-second forwarded; auxiliary stamp trigger returned
module mcs_splitter #(
  parameter logic [1:0] FAMILY = mcs_pkg::FAMILY_AGENT
) (
  input  wire logic                 clk,
  input  wire logic                 rst,
  // APB agent
  input  wire mcs_pkg::mcs_apb_req_t apbReq,
  output logic [31:0]               prdata,
  output logic                      pready,
  output logic                      pslverr,
  // Host MAC conduit
  input  wire mcs_pkg::mcs_tx_t     conduitTx,
  output mcs_pkg::mcs_rx_t          conduitRx,
  input  wire logic [1:0]           conduitSpeed,
  input  wire mcs_pkg::mcs_mgmt_t   conduitMgmt,
  output logic                      conduitMgmtIn,
  input  wire logic                 conduitPps,
  output logic                      conduit_aux_stamp_trigger,
  // Media-side group
  output mcs_pkg::mcs_tx_t          mediaTx,
  input  wire mcs_pkg::mcs_rx_t     mediaRx,
  output logic [1:0]                mediaSpeed,
  // Management group
  output mcs_pkg::mcs_mgmt_t        mgmtOut,
  input  wire logic                 mgmtIn,
  // Precision-time group
  output logic                      timePps,
  input  wire logic                 timeAuxTrigger
);
  import mcs_pkg::*;

  // ----------------------------------------------------------------
  // Build-time options
  // ----------------------------------------------------------------
  // Option follows the family only
  localparam bit speed_register_option = (FAMILY == FAMILY_AGENT);

  // ----------------------------------------------------------------
  // APB agent and speed register
  // ----------------------------------------------------------------
  logic [SPEED_W-1:0] speed_q;
  logic [SPEED_W-1:0] speed_d;
  logic [31:0]        prdata_q;
  logic [31:0]        prdata_d;
  logic               pready_q;
  logic               pready_d;
  logic               pslverr_q;
  logic               pslverr_d;
  logic               setupPhase;

  assign setupPhase = apbReq.psel && !apbReq.penable;

  // Decode setup cycle; answer in the access cycle
  always_comb
  begin
    speed_d   = speed_q;
    prdata_d  = prdata_q;
    pready_d  = 1'b0;
    pslverr_d = 1'b0;
    if (setupPhase)
    begin
      pready_d = 1'b1;
      prdata_d = UNMAPPED_DATA;
      if (!speed_register_option)
        pslverr_d = 1'b1;
      else if (apbReq.paddr == SPEED_CTRL_ADDR)
      begin
        if (apbReq.pwrite)
          speed_d = apbReq.pwdata[SPEED_W-1:0];
        else
          prdata_d = {30'h0000_0000, speed_q};
      end
      else if (apbReq.paddr == STATUS_ADDR)
      begin
        if (!apbReq.pwrite)
          prdata_d = {30'h0000_0000, mediaSpeed};
      end
      else
        pslverr_d = 1'b1;
    end
  end

  // Register agent state
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      speed_q   <= SPEED_RESET;
      prdata_q  <= 32'h0000_0000;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end
    else
    begin
      speed_q   <= speed_d;
      prdata_q  <= prdata_d;
      pready_q  <= pready_d;
      pslverr_q <= pslverr_d;
    end
  end

  assign prdata  = prdata_q;
  assign pready  = pready_q;
  assign pslverr = pslverr_q;

  // ----------------------------------------------------------------
  // Signal regrouping
  // ----------------------------------------------------------------
  // Plain rerouting, no alteration
  assign mediaTx                   = conduitTx;
  assign conduitRx                 = mediaRx;
  assign mgmtOut                   = conduitMgmt;
  assign conduitMgmtIn             = mgmtIn;
  assign timePps                   = conduitPps;
  assign conduit_aux_stamp_trigger = timeAuxTrigger;

  // Speed source chosen at build time; speed input unused in agent family
  assign mediaSpeed = speed_register_option ? speed_q : conduitSpeed;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  speed_write_a: assert property (@(posedge clk) disable iff (rst)
    (speed_register_option && apbReq.psel && !apbReq.penable && apbReq.pwrite
     && apbReq.paddr == SPEED_CTRL_ADDR)
    |=> (mediaSpeed == $past(apbReq.pwdata[1:0])))
    else $error("speed register write not applied");

  speed_read_a: assert property (@(posedge clk) disable iff (rst)
    (speed_register_option && apbReq.psel && !apbReq.penable && !apbReq.pwrite
     && apbReq.paddr == SPEED_CTRL_ADDR)
    |=> (prdata == {30'h0000_0000, speed_q} && pready))
    else $error("speed register read data wrong");

  speed_pass_a: assert property (@(posedge clk) disable iff (rst)
    !speed_register_option |-> mediaSpeed == conduitSpeed)
    else $error("speed not passed through");

  speed_hold_a: assert property (@(posedge clk) disable iff (rst)
    (speed_register_option && !(apbReq.psel && apbReq.pwrite)) |=> $stable(mediaSpeed))
    else $error("speed changed without write");

  tx_route_a: assert property (@(posedge clk) disable iff (rst)
    mediaTx == conduitTx)
    else $error("transmit group altered");

  rx_route_a: assert property (@(posedge clk) disable iff (rst)
    conduitRx == mediaRx)
    else $error("receive group altered");

  mgmt_route_a: assert property (@(posedge clk) disable iff (rst)
    mgmtOut == conduitMgmt && conduitMgmtIn == mgmtIn)
    else $error("management group altered");

  time_route_a: assert property (@(posedge clk) disable iff (rst)
    timePps == conduitPps && conduit_aux_stamp_trigger == timeAuxTrigger)
    else $error("time group altered");

  ready_pulse_a: assert property (@(posedge clk) disable iff (rst)
    pready |=> !pready)
    else $error("ready held longer than one cycle");

  // ----------------------------------------------------------------
  // Agent response checks
  // ----------------------------------------------------------------
  // Every setup cycle gets its answer in the next cycle
  ready_answer_a: assert property (@(posedge clk) disable iff (rst)
    setupPhase
    |=> pready)
    else $error("setup cycle not answered");

  // Ready only ever follows a setup cycle
  ready_setup_a: assert property (@(posedge clk) disable iff (rst)
    pready
    |-> $past(setupPhase))
    else $error("ready without setup");

  // Error only ever rides on ready
  err_with_ready_a: assert property (@(posedge clk) disable iff (rst)
    pslverr
    |-> pready)
    else $error("error outside answer");

  // Family without agent refuses every access
  native_refuse_a: assert property (@(posedge clk) disable iff (rst)
    (!speed_register_option && setupPhase)
    |=> (pslverr && pready))
    else $error("access accepted without agent");

  // Family without agent reads back nothing
  native_zero_a: assert property (@(posedge clk) disable iff (rst)
    (!speed_register_option && setupPhase)
    |=> (prdata == UNMAPPED_DATA))
    else $error("data returned without agent");

  // Unmapped address flags an error
  unmapped_err_a: assert property (@(posedge clk) disable iff (rst)
    (speed_register_option && setupPhase && apbReq.paddr != SPEED_CTRL_ADDR
     && apbReq.paddr != STATUS_ADDR)
    |=> pslverr)
    else $error("unmapped access not refused");

  // Unmapped address reads as zero
  unmapped_data_a: assert property (@(posedge clk) disable iff (rst)
    (speed_register_option && setupPhase && apbReq.paddr != SPEED_CTRL_ADDR
     && apbReq.paddr != STATUS_ADDR)
    |=> (prdata == UNMAPPED_DATA))
    else $error("unmapped read not zero");

  // Writes elsewhere leave the speed register alone
  unmapped_keep_a: assert property (@(posedge clk) disable iff (rst)
    (speed_register_option && setupPhase && apbReq.pwrite
     && apbReq.paddr != SPEED_CTRL_ADDR)
    |=> $stable(speed_q))
    else $error("speed changed by foreign write");

  // Mapped addresses answer without error
  mapped_ok_a: assert property (@(posedge clk) disable iff (rst)
    (speed_register_option && setupPhase
     && (apbReq.paddr == SPEED_CTRL_ADDR || apbReq.paddr == STATUS_ADDR))
    |=> !pslverr)
    else $error("mapped access refused");

  // Status read mirrors the live speed output
  status_read_a: assert property (@(posedge clk) disable iff (rst)
    (speed_register_option && setupPhase && !apbReq.pwrite && apbReq.paddr == STATUS_ADDR)
    |=> (prdata == {30'h0000_0000, mediaSpeed}))
    else $error("status read wrong");

  // Speed read matches the driven speed
  read_stable_a: assert property (@(posedge clk) disable iff (rst)
    (speed_register_option && setupPhase && !apbReq.pwrite
     && apbReq.paddr == SPEED_CTRL_ADDR)
    |=> (prdata[1:0] == mediaSpeed))
    else $error("speed read differs from output");

  // Write answers carry no read data
  write_data_a: assert property (@(posedge clk) disable iff (rst)
    (setupPhase && apbReq.pwrite)
    |=> (prdata == UNMAPPED_DATA))
    else $error("write answer carries data");

  // Upper read bits always zero
  read_upper_a: assert property (@(posedge clk) disable iff (rst)
    pready
    |-> (prdata[31:2] == 30'h0000_0000))
    else $error("read data not zero-extended");

  // ----------------------------------------------------------------
  // Speed source checks
  // ----------------------------------------------------------------
  // Agent family drives speed from the register
  speed_select_a: assert property (@(posedge clk) disable iff (rst)
    speed_register_option
    |-> (mediaSpeed == speed_q))
    else $error("speed not from register");

  // Native family never touches the register
  native_keep_a: assert property (@(posedge clk) disable iff (rst)
    !speed_register_option
    |=> $stable(speed_q))
    else $error("register written without agent");

  // ----------------------------------------------------------------
  // Routing detail checks
  // ----------------------------------------------------------------
  // Transmit qualifiers forwarded bit for bit
  tx_enable_a: assert property (@(posedge clk) disable iff (rst)
    (mediaTx.enable == conduitTx.enable)
    && (mediaTx.error == conduitTx.error))
    else $error("transmit qualifiers altered");

  // Receive line states returned bit for bit
  rx_flags_a: assert property (@(posedge clk) disable iff (rst)
    (conduitRx.collision == mediaRx.collision)
    && (conduitRx.carrier == mediaRx.carrier))
    else $error("receive line states altered");

  // Management output enable forwarded
  mgmt_enable_a: assert property (@(posedge clk) disable iff (rst)
    mgmtOut.dataOutEn == conduitMgmt.dataOutEn)
    else $error("management enable altered");

  // Pulse-per-second edges kept
  pps_edge_a: assert property (@(posedge clk) disable iff (rst)
    $rose(conduitPps)
    |-> $rose(timePps))
    else $error("pulse edge lost");

  // Auxiliary trigger edges kept
  aux_edge_a: assert property (@(posedge clk) disable iff (rst)
    $rose(timeAuxTrigger)
    |-> $rose(conduit_aux_stamp_trigger))
    else $error("trigger edge lost");

endmodule : mcs_splitter

`default_nettype wire

// ### shared/mcs_pkg.sv
package mcs_pkg;

  // ----------------------------------------------------------------
  // Family selection
  // ----------------------------------------------------------------
  // Family with the peripheral agent and speed register
  localparam logic [1:0] FAMILY_AGENT = 2'h0;
  // Family with a native speed output from the MAC
  localparam logic [1:0] FAMILY_NATIVE = 2'h1;

  // ----------------------------------------------------------------
  // Register map (byte addresses on APB)
  // ----------------------------------------------------------------
  localparam logic [11:0] SPEED_CTRL_IDX  = 12'h000;
  localparam logic [11:0] SPEED_CTRL_ADDR = 12'h000;
  localparam logic [11:0] STATUS_ADDR     = 12'h004;
  localparam int          SPEED_W         = 2;
  localparam logic [1:0]  SPEED_RESET     = 2'h0;
  localparam logic [31:0] UNMAPPED_DATA   = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] data;
    logic       enable;
    logic       error;
  } mcs_tx_t;

  typedef struct packed {
    logic [7:0] data;
    logic       valid;
    logic       error;
    logic       collision;
    logic       carrier;
  } mcs_rx_t;

  typedef struct packed {
    logic       dataOut;
    logic       dataOutEn;
  } mcs_mgmt_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } mcs_apb_req_t;

endpackage : mcs_pkg

// ### verif/mcs_media_model.sv
`timescale 1ns/1ps
`default_nettype none
// Stand-in for the media, management and time side
module mcs_media_model (
  input  wire logic       clk,
  input  wire logic       rst,
  output mcs_pkg::mcs_rx_t mediaRx,
  output logic            mgmtIn,
  output logic            timeAuxTrigger
);
  import mcs_pkg::*;
  logic [11:0] cnt_q;
  // Fresh pattern every cycle so a stale pass shows
  always_ff @(posedge clk or posedge rst)
    if (rst)
      cnt_q <= 12'h000;
    else
      cnt_q <= cnt_q + 12'h5A7;
  assign mediaRx        = cnt_q;
  assign mgmtIn         = cnt_q[3];
  assign timeAuxTrigger = cnt_q[6];
endmodule : mcs_media_model
`default_nettype wire

// ### verif/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import mcs_pkg::*;
  logic clk, rst, conduitPps, conduitMgmtIn, auxTrig, mgmtIn, timeAux, timePps, pready, pslverr;
  logic [1:0] conduitSpeed, mediaSpeed, speedNat;
  logic [31:0] prdata, rd;
  logic err, errNat, errN;
  mcs_apb_req_t apbReq;
  mcs_tx_t conduitTx, mediaTx;
  mcs_rx_t conduitRx, mediaRx;
  mcs_mgmt_t conduitMgmt, mgmtOut;
  int num_errors, check_count;
  // Rows of {tx, mgmt, pps, speed}
  logic [14:0] rows [4] = '{15'h0000, 15'h7FFF, 15'h2AAA, 15'h5555};
  // 200 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  mcs_splitter i_mcs_splitter (.clk(clk), .rst(rst), .apbReq(apbReq), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .conduitTx(conduitTx), .conduitRx(conduitRx),
    .conduitSpeed(conduitSpeed), .conduitMgmt(conduitMgmt), .conduitMgmtIn(conduitMgmtIn),
    .conduitPps(conduitPps), .conduit_aux_stamp_trigger(auxTrig), .mediaTx(mediaTx),
    .mediaRx(mediaRx), .mediaSpeed(mediaSpeed), .mgmtOut(mgmtOut), .mgmtIn(mgmtIn),
    .timePps(timePps), .timeAuxTrigger(timeAux));
  // Native-speed family, only its speed and error outputs are watched
  mcs_splitter #(.FAMILY(FAMILY_NATIVE)) i_mcs_splitter_native (.clk(clk), .rst(rst),
    .apbReq(apbReq), .prdata(), .pready(), .pslverr(errNat), .conduitTx(conduitTx), .conduitRx(),
    .conduitSpeed(conduitSpeed), .conduitMgmt(conduitMgmt), .conduitMgmtIn(), .conduitPps(conduitPps),
    .conduit_aux_stamp_trigger(), .mediaTx(), .mediaRx(mediaRx), .mediaSpeed(speedNat),
    .mgmtOut(), .mgmtIn(mgmtIn), .timePps(), .timeAuxTrigger(timeAux));
  mcs_media_model i_mcs_media_model (.clk(clk), .rst(rst), .mediaRx(mediaRx), .mgmtIn(mgmtIn),
    .timeAuxTrigger(timeAux));
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic print_verdict;
    if (num_errors == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : print_verdict
  // One transfer; request stays up so the next setup may follow at once
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    apbReq <= '{1'b1, 1'b0, w, a, d};
    @(posedge clk);
    apbReq.penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 16);
    rd = prdata;
    err = pslverr;
    errN = errNat;
    if (n >= 16)
    begin
      num_errors++;
      print_verdict();
    end
  endtask : apb
  // Main sequence
  initial
  begin
    rst = 1'b1;
    apbReq = '0;
    {conduitTx, conduitMgmt, conduitPps, conduitSpeed} = '0;
    num_errors = 0;
    check_count = 0;
    repeat (6) @(posedge clk);
    chk(mediaSpeed, SPEED_RESET);
    chk(pready, 1'b0);
    rst <= 1'b0;
    for (int i = 0; i < 4; i++)
    begin
      {conduitTx, conduitMgmt, conduitPps, conduitSpeed} <= rows[i];
      @(posedge clk);
      #1;
      chk({mediaTx, mgmtOut, timePps}, rows[i][14:2]);
      chk(conduitRx, mediaRx);
      chk({conduitMgmtIn, auxTrig}, {mgmtIn, timeAux});
      chk(speedNat, rows[i][1:0]);
      chk(mediaSpeed, SPEED_RESET);
    end
    @(posedge clk);
    apb(1'b1, SPEED_CTRL_ADDR, 32'hFFFF_FFF3);
    chk(err, 1'b0);
    chk(errN, 1'b1);
    apb(1'b0, SPEED_CTRL_ADDR, 32'h0);
    chk(rd, 32'h3);
    apb(1'b0, STATUS_ADDR, 32'h0);
    chk(rd, 32'h3);
    apb(1'b1, 12'h008, 32'h1);
    chk(err, 1'b1);
    apb(1'b0, SPEED_CTRL_ADDR, 32'h0);
    chk(rd, 32'h3);
    apbReq <= '0;
    @(posedge clk);
    #1;
    chk(mediaSpeed, 2'h3);
    chk(speedNat, conduitSpeed);
    @(posedge clk);
    rst <= 1'b1;
    @(posedge clk);
    #1;
    chk(mediaSpeed, SPEED_RESET);
    chk(prdata, UNMAPPED_DATA);
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    apb(1'b0, SPEED_CTRL_ADDR, 32'h0);
    chk(rd, {30'h0, SPEED_RESET});
    chk(errN, 1'b1);
    apbReq <= '0;
    @(posedge clk);
    print_verdict();
  end
endmodule : testbench
`default_nettype wire
